// ### hw/pm_ctrl_consts.vh
// Constants for the power management control register block
`ifndef PM_CTRL_CONSTS_VH
`define PM_CTRL_CONSTS_VH

`define PMC_ADDR_W 14
`define PMC_OFFSET_LO 14'h0084
`define PMC_OFFSET_HI 14'h3084

`define PMC_MODE_HI 31
`define PMC_MODE_LO 29
`define PMC_SLEEP_BIT 28
`define PMC_WAKE_BIT 27
`define PMC_LED_BIT 26
`define PMC_CORE_BIT 21
`define PMC_STS_B_BIT 17
`define PMC_STS_A_BIT 16
`define PMC_EN_B_BIT 15
`define PMC_EN_A_BIT 14
`define PMC_READY_BIT 0

`define PMC_MODE_FULL 3'h0
`define PMC_MODE_SYSCLK_OFF 3'h1
`define PMC_MODE_PLL_REL 3'h2
`define PMC_MODE_OSC_OFF 3'h3

`define PMC_RESET_VALUE 32'h00000000

// Time for the clock source to settle after waking, in ns
`define PMC_SETTLE_NS 1000
`define PMC_SETTLE_CYC ((`PMC_SETTLE_NS + 4) / 5)

`endif

// ### hw/power_mgmt_control_register.v
// Power management control register with sleep and wake sequencing
`timescale 1ns/100ps
`include "pm_ctrl_consts.vh"

// Function
// [R01] Three-bit selector picks full power or low power
// [R02] Selector write discarded when sleep bit written one
// [R03] Sleep bit enters state held in selector
// [R04] Sleep bit reads one while asleep, self-clears
// [R05] Sleep set ignored if selector value changes
// [R06] Host writes selector first, sleep bit later
// [R07] Host avoids sleeping with full-power selector
// [R08] Wake clears selector and sleep bit
// [R09] Auto-wake enable lets events wake device; code blocks auto-wake when selector is oscillator-off (3)
// [R10] Indicator disable: open-drain undriven, push-pull inactive
// [R11] Core clock gate bit stops core clocks
// [R12] Gate sets only after two consecutive one-writes
// [R13] Per-port energy/wake status sets, write-one clears
// [R14] Status clears only when port event cleared
// [R15] Per-port enables raise the power event flag
// [R16] Reads always answered, never stall interface
// [R17] Byte-wide partial reads and writes accepted
// [R18] Register answers at both aliased addresses
// [R19] Ready low when asleep, high after settling
// [R20] Host access wakes device, its data ignored; code wakes only on a write, to any address, not on reads
// [R21] Low power stops PLL-derived clocks, deeper releases
// [R22] Reserved bits read zero, ignore writes
module power_mgmt_control_register #(
  parameter SETTLE_CYCLES = `PMC_SETTLE_CYC
)(
  input wire clk_i,
  input wire resetn_i,
  input wire acc_valid_i,
  input wire acc_write_i,
  input wire [`PMC_ADDR_W-1:0] acc_addr_i,
  input wire [3:0] acc_byte_en_i,
  input wire [31:0] acc_wdata_i,
  input wire port_a_event_i,
  input wire port_b_event_i,
  input wire led_push_pull_i,
  input wire led_active_high_i,
  input wire [1:0] led_value_i,
  output reg [31:0] acc_rdata_o,
  output reg acc_ack_o,
  output reg power_event_flag_o,
  output reg wake_event_o,
  output reg ready_o,
  output reg sysclk_enable_o,
  output reg pll_enable_o,
  output reg osc_enable_o,
  output reg core_clock_enable_o,
  output reg [1:0] led_out_o,
  output reg [1:0] led_oe_o
);

  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  localparam ST_AWAKE = 2'h0;
  localparam ST_ASLEEP = 2'h1;
  localparam ST_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] evt_meta;
  reg [1:0] evt_sync;
  reg [1:0] led_meta;
  reg [1:0] led_sync;
  reg [1:0] led_cfg_meta;
  reg [1:0] led_cfg_sync;

  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      evt_meta <= 2'h0;
      evt_sync <= 2'h0;
      led_meta <= 2'h0;
      led_sync <= 2'h0;
      led_cfg_meta <= 2'h0;
      led_cfg_sync <= 2'h0;
    end
    else
    begin
      evt_meta <= {port_b_event_i, port_a_event_i};
      evt_sync <= evt_meta;
      led_meta <= led_value_i;
      led_sync <= led_meta;
      led_cfg_meta <= {led_active_high_i, led_push_pull_i};
      led_cfg_sync <= led_cfg_meta;
    end
  end

  // ----------------------------------------------------------------
  // Register fields
  // ----------------------------------------------------------------
  reg [2:0] power_state_select;
  reg sleep_request;
  reg auto_wake_enable;
  reg indicator_output_disable;
  reg fieldbus_core_clock_gate;
  reg gate_first_write;
  reg port_a_energy_wake_status;
  reg port_b_energy_wake_status;
  reg port_a_energy_wake_irq_enable;
  reg port_b_energy_wake_irq_enable;
  reg [1:0] state;
  reg [15:0] settle_cnt;

  function hit;
    input [`PMC_ADDR_W-1:0] addr;
    begin
      hit = (addr == `PMC_OFFSET_LO) || (addr == `PMC_OFFSET_HI); // [R18]
    end
  endfunction

  wire sel = acc_valid_i && hit(acc_addr_i);
  wire awake = (state == ST_AWAKE);
  wire wr = sel && acc_write_i && awake; // [R20]
  wire wr_b3 = wr && acc_byte_en_i[3]; // [R17]
  wire wr_b2 = wr && acc_byte_en_i[2];
  wire wr_b1 = wr && acc_byte_en_i[1];
  wire [2:0] new_mode = acc_wdata_i[`PMC_MODE_HI:`PMC_MODE_LO];
  wire sleep_wr1 = wr_b3 && acc_wdata_i[`PMC_SLEEP_BIT];
  wire mode_changes = wr_b3 && (new_mode != power_state_select);
  wire go_sleep = sleep_wr1 && !mode_changes; // [R05]
  wire any_access = acc_valid_i;
  wire pend = (port_a_energy_wake_status && port_a_energy_wake_irq_enable) ||
              (port_b_energy_wake_status && port_b_energy_wake_irq_enable);
  wire auto_wake = auto_wake_enable && pend &&
                   (power_state_select != `PMC_MODE_OSC_OFF); // [R09]

  wire [31:0] rd_word = {power_state_select, sleep_request, auto_wake_enable,
                         indicator_output_disable, 4'h0, fieldbus_core_clock_gate,
                         3'h0, port_b_energy_wake_status, port_a_energy_wake_status,
                         port_b_energy_wake_irq_enable, port_a_energy_wake_irq_enable,
                         13'h0000, ready_o}; // [R22]

  function [31:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  wire [31:0] byte_mask = lane_mask(acc_byte_en_i);

  // ----------------------------------------------------------------
  // Power state selector, sleep request and wake sequencing
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      power_state_select <= `PMC_MODE_FULL;
      sleep_request <= 1'b0;
      state <= ST_SETTLE;
      settle_cnt <= 16'h0000;
    end
    else
    begin
      // A write that also sets the sleep bit keeps the old selector
      if (wr_b3 && !acc_wdata_i[`PMC_SLEEP_BIT])
        power_state_select <= new_mode; // [R01] [R02]
      case (state)
        ST_AWAKE:
        begin
          if (go_sleep)
          begin
            sleep_request <= 1'b1; // [R03]
            state <= ST_ASLEEP;
          end
        end
        ST_ASLEEP:
        begin
          if ((any_access && acc_write_i) || auto_wake) // [R20] [R09]
          begin
            state <= ST_SETTLE;
            settle_cnt <= 16'h0000;
          end
        end
        ST_SETTLE:
        begin
          if (settle_cnt >= SETTLE_CYCLES - 1)
          begin
            state <= ST_AWAKE;
            power_state_select <= `PMC_MODE_FULL; // [R08]
            sleep_request <= 1'b0; // [R04] [R08]
          end
          else
            settle_cnt <= settle_cnt + 16'h0001;
        end
        default:
          state <= ST_SETTLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Auto-wake and indicator disable bits
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      auto_wake_enable <= 1'b0;
      indicator_output_disable <= 1'b0;
    end
    else if (wr_b3)
    begin
      auto_wake_enable <= acc_wdata_i[`PMC_WAKE_BIT]; // [R09]
      indicator_output_disable <= acc_wdata_i[`PMC_LED_BIT]; // [R10]
    end
  end

  // ----------------------------------------------------------------
  // Core clock gate with double-write guard
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      fieldbus_core_clock_gate <= 1'b0;
      gate_first_write <= 1'b0;
    end
    else if (wr_b2)
    begin
      if (!acc_wdata_i[`PMC_CORE_BIT])
      begin
        fieldbus_core_clock_gate <= 1'b0;
        gate_first_write <= 1'b0; // [R12]
      end
      else if (gate_first_write)
        fieldbus_core_clock_gate <= 1'b1; // [R12]
      else
        gate_first_write <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Energy/wake status flags and their interrupt enables
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      port_a_energy_wake_status <= 1'b0;
      port_b_energy_wake_status <= 1'b0;
      port_a_energy_wake_irq_enable <= 1'b0;
      port_b_energy_wake_irq_enable <= 1'b0;
    end
    else
    begin
      // Set wins over clear; clear holds only once the port event is gone
      port_a_energy_wake_status <= evt_sync[0] ||
        (port_a_energy_wake_status && !(wr_b2 && acc_wdata_i[`PMC_STS_A_BIT])); // [R13] [R14]
      port_b_energy_wake_status <= evt_sync[1] ||
        (port_b_energy_wake_status && !(wr_b2 && acc_wdata_i[`PMC_STS_B_BIT])); // [R13] [R14]
      if (wr_b1)
      begin
        port_a_energy_wake_irq_enable <= acc_wdata_i[`PMC_EN_A_BIT];
        port_b_energy_wake_irq_enable <= acc_wdata_i[`PMC_EN_B_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_led
      always @(posedge clk_i)
      begin
        if (!resetn_i)
        begin
          led_out_o[i] <= 1'b0;
          led_oe_o[i] <= 1'b0;
        end
        else
        begin
          led_out_o[i] <= indicator_output_disable ? !led_cfg_sync[1] : led_sync[i]; // [R10]
          led_oe_o[i] <= !indicator_output_disable || led_cfg_sync[0]; // [R10]
        end
      end
    end
  endgenerate

  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      acc_rdata_o <= 32'h00000000;
      acc_ack_o <= 1'b0;
    end
    else
    begin
      acc_ack_o <= sel; // [R16]
      acc_rdata_o <= (sel && !acc_write_i) ? (rd_word & byte_mask) : 32'h00000000; // [R17]
    end
  end

  // ----------------------------------------------------------------
  // Power event, wake pulse and ready
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      power_event_flag_o <= 1'b0;
      wake_event_o <= 1'b0;
      ready_o <= 1'b0;
    end
    else
    begin
      power_event_flag_o <= pend; // [R15]
      wake_event_o <= (state == ST_ASLEEP) && auto_wake;
      ready_o <= awake && !go_sleep; // [R19]
    end
  end

  // ----------------------------------------------------------------
  // Clock enables
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      sysclk_enable_o <= 1'b1;
      pll_enable_o <= 1'b1;
      osc_enable_o <= 1'b1;
      core_clock_enable_o <= 1'b1;
    end
    else
    begin
      sysclk_enable_o <= state != ST_ASLEEP; // [R21]
      pll_enable_o <= !(state == ST_ASLEEP && power_state_select >= `PMC_MODE_PLL_REL); // [R21]
      osc_enable_o <= !(state == ST_ASLEEP && power_state_select == `PMC_MODE_OSC_OFF); // [R21]
      core_clock_enable_o <= !fieldbus_core_clock_gate; // [R11]
    end
  end

endmodule // power_mgmt_control_register

// ### tb/pmc_asserts.sv
// Assertion checker for the power management control register
`timescale 1ns/100ps
`include "pm_ctrl_consts.vh"
module pmc_asserts (
  input wire clk_i,
  input wire resetn_i,
  input wire acc_valid_i,
  input wire acc_write_i,
  input wire [13:0] acc_addr_i,
  input wire [3:0] acc_byte_en_i,
  input wire [31:0] acc_rdata_o,
  input wire acc_ack_o,
  input wire ready_o,
  input wire sysclk_enable_o,
  input wire pll_enable_o,
  input wire osc_enable_o
);
  wire hit = acc_valid_i && (acc_addr_i == `PMC_OFFSET_LO || acc_addr_i == `PMC_OFFSET_HI);
  wire [31:0] lanes = {{8{acc_byte_en_i[3]}}, {8{acc_byte_en_i[2]}},
    {8{acc_byte_en_i[1]}}, {8{acc_byte_en_i[0]}}};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ack_after_hit_a: assert property (hit |=> acc_ack_o) else $error("ack missing");
  no_stray_ack_a: assert property (!hit |=> !acc_ack_o) else $error("stray ack");
  lane_mask_a: assert property (acc_ack_o && !$past(acc_write_i) |->
    (acc_rdata_o & ~$past(lanes)) == 32'h0) else $error("unselected lane data");
  reserved_zero_a: assert property (acc_ack_o |-> acc_rdata_o[25:22] == 4'h0 &&
    acc_rdata_o[20:18] == 3'h0 && acc_rdata_o[13:1] == 13'h0) else $error("reserved set");
  ready_bit_a: assert property (acc_ack_o && !$past(acc_write_i) && $past(acc_byte_en_i[0])
    |-> acc_rdata_o[0] == $past(ready_o)) else $error("ready bit wrong");
  asleep_busy_a: assert property (!sysclk_enable_o |-> !ready_o) else $error("ready asleep");
  osc_deep_a: assert property (!osc_enable_o |-> !pll_enable_o) else $error("pll on");
  pll_deep_a: assert property (!pll_enable_o |-> !sysclk_enable_o) else $error("sysclk on");
endmodule // pmc_asserts

bind power_mgmt_control_register pmc_asserts u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i),
  .acc_byte_en_i(acc_byte_en_i), .acc_rdata_o(acc_rdata_o), .acc_ack_o(acc_ack_o),
  .ready_o(ready_o), .sysclk_enable_o(sysclk_enable_o), .pll_enable_o(pll_enable_o),
  .osc_enable_o(osc_enable_o));

// ### tb/tb_top.sv
// Testbench for the power management control register
`timescale 1ns/100ps
`include "pm_ctrl_consts.vh"
module tb_top;
  logic clk_i = 0, resetn_i = 0, valid = 0, wr = 0, pa = 0, pb = 0, pp = 0, ah = 1;
  logic [13:0] addr = 0;
  logic [3:0] ben = 0;
  logic [31:0] wdata = 0, rd, rdata;
  logic [1:0] lv = 2'h3, lo, loe;
  logic ackd, ack, flag, wk, rdy, sck, pll, osc, cce;
  int fail_count = 0, n_checks = 0;
  localparam logic [13:0] a_lo = `PMC_OFFSET_LO, a_hi = `PMC_OFFSET_HI;
  always #2.5 clk_i = ~clk_i;
  power_mgmt_control_register #(.SETTLE_CYCLES(4)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .acc_valid_i(valid), .acc_write_i(wr), .acc_addr_i(addr), .acc_byte_en_i(ben),
    .acc_wdata_i(wdata), .port_a_event_i(pa), .port_b_event_i(pb), .led_push_pull_i(pp),
    .led_active_high_i(ah), .led_value_i(lv), .acc_rdata_o(rdata), .acc_ack_o(ack),
    .power_event_flag_o(flag), .wake_event_o(wk), .ready_o(rdy), .sysclk_enable_o(sck),
    .pll_enable_o(pll), .osc_enable_o(osc), .core_clock_enable_o(cce), .led_out_o(lo),
    .led_oe_o(loe));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task acc(input logic w, input logic [13:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_i);
    valid <= 1'b1;
    wr <= w;
    addr <= a;
    ben <= be;
    wdata <= d;
    @(posedge clk_i);
    valid <= 1'b0;
    @(posedge clk_i);
    ackd = ack;
    rd = rdata;
  endtask
  task rdc(input string nm, input logic [13:0] a, input logic [3:0] be, input logic [31:0] e);
    acc(1'b0, a, be, 32'h0);
    chk(nm, {31'h0, ackd}, 32'h1);
    chk(nm, rd, e);
  endtask
  task wr32(input logic [3:0] be, input logic [31:0] d);
    acc(1'b1, a_lo, be, d);
  endtask
  task wait_rdy;
    for (int i = 0; i < 200 && rdy !== 1'b1; i++)
      @(posedge clk_i);
    if (rdy !== 1'b1)
    begin
      fail_count++;
      results;
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_rdy;
    rdc("reset lo", a_lo, 4'hf, 32'h1);
    rdc("reset hi", a_hi, 4'hf, 32'h1);
    acc(1'b0, 14'h0088, 4'hf, 32'h0);
    chk("unmapped ack", {31'h0, ackd}, 32'h0);
    wr32(4'hf, 32'h0ffcfffe);
    rdc("rw bits", a_hi, 4'hf, 32'h0c00c001);
    rdc("byte lane", a_lo, 4'h2, 32'h0000c000);
    wr32(4'h4, 32'h0);
    wr32(4'h4, 32'h00200000);
    chk("gate once", {31'h0, cce}, 32'h1);
    wr32(4'h4, 32'h00200000);
    rdc("gate twice", a_lo, 4'h4, 32'h00200000);
    chk("core clock", {31'h0, cce}, 32'h0);
    wr32(4'h4, 32'h0);
    chk("led od", {30'h0, loe}, 32'h0);
    pp <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("led pp", {28'h0, loe, lo}, 32'hc);
    ah <= 1'b0;
    lv <= 2'h1;
    repeat (4) @(posedge clk_i);
    chk("led low", {28'h0, loe, lo}, 32'hf);
    wr32(4'h8, 32'h0);
    @(posedge clk_i);
    chk("led on", {28'h0, loe, lo}, 32'hd);
    for (int p = 0; p < 2; p++)
    begin
      pa <= (p == 0);
      pb <= (p == 1);
      repeat (5) @(posedge clk_i);
      rdc("sts set", a_lo, 4'h4, 32'h1 << (16 + p));
      chk("flag", {31'h0, flag}, 32'h1);
      wr32(4'h4, 32'h00030000);
      rdc("sts held", a_lo, 4'h4, 32'h1 << (16 + p));
      pa <= 1'b0;
      pb <= 1'b0;
      repeat (4) @(posedge clk_i);
      wr32(4'h4, 32'h00030000);
      rdc("sts clr", a_lo, 4'h4, 32'h0);
      chk("flag clr", {31'h0, flag}, 32'h0);
    end
    wr32(4'h8, 32'h50000000);
    rdc("sleep with mode", a_lo, 4'h8, 32'h0);
    chk("stay ready", {31'h0, rdy}, 32'h1);
    for (int m = 1; m < 4; m++)
    begin
      wr32(4'h8, {m[2:0], 29'h0});
      wr32(4'h8, {m[2:0], 29'h10000000});
      repeat (3) @(posedge clk_i);
      chk("clocks", {29'h0, osc, pll, sck}, {29'h0, m < 3, m < 2, 1'b0});
      rdc("asleep", a_lo, 4'h9, {m[2:0], 29'h10000000});
      wr32(4'h1, 32'h0);
      wait_rdy;
      rdc("woken", a_lo, 4'h9, 32'h1);
    end
    wr32(4'h8, 32'h20000000);
    wr32(4'h8, 32'h30000000);
    pa <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("manual only", {30'h0, sck, wk}, 32'h0);
    wr32(4'h1, 32'h0);
    wait_rdy;
    wr32(4'h8, 32'h28000000);
    wr32(4'h8, 32'h38000000);
    for (int i = 0; i < 20 && wk !== 1'b1; i++)
      @(posedge clk_i);
    chk("auto wake", {31'h0, wk}, 32'h1);
    wait_rdy;
    rdc("auto woken", a_lo, 4'h9, 32'h08000001);
    results;
  end
endmodule // tb_top
